// [shared/rxdes_pkg.sv]
// Constants and types shared by the receive descriptor and statistics engine.
//===========================================================================
// What this block does
// - Statistics counters in the init area are only ever incremented, never cleared.
// - Count reject-information frames at base+46 and retransmit timeouts at base+48.
// - Count received REJ frames at base+50, transmitted REJ frames at base+52.
// - Count short frames at base+54, bad check or misaligned frames at base+44.
// - Count aborted frames at base+56 only while abort counting is enabled.
// - Every descriptor entry is four consecutive 16-bit words.
// - Word 0 bit 15 is ownership: one means the device owns the entry.
// - Word 0 bit 14 picks host or helper; the device ignores it.
// - Bit 13 is set in the first buffer of a received frame.
// - Bit 12 is set in the last buffer; single-buffer frames get both.
// - Bit 11 is set when the buffer holds a received UI frame.
// - Bit 10 flags reject info, or bad check in transparent acceptance mode.
// - Bit 9 shows local address match under transparent address filtering.
// - Bit 8 copies poll/final for received UI, XID and TEST frames.
// - Buffer address fields in word 0 low byte and word 1 stay unaltered.
// - Word 2 buffer length is read by the device, never modified.
// - Word 3 gets the negated frame length when last, plus check bytes.
package rxdes_pkg;
  //=========================================================================
  // Memory layout
  localparam int CNT_NUM = 7;
  localparam logic [23:0] CNT_BASE_OFS = 24'h00002c;
  localparam logic [23:0] CNT_STEP = 24'h000002;
  localparam int CNT_ABORT = 6;
  localparam logic [23:0] DW0_OFS = 24'h000000;
  localparam logic [23:0] DW1_OFS = 24'h000002;
  localparam logic [23:0] DW2_OFS = 24'h000004;
  localparam logic [23:0] DW3_OFS = 24'h000006;
  localparam int ENTRY_SHIFT = 3;
  localparam int OWN_BIT = 15;
  localparam int SEC_BIT = 14;
  localparam int ADDR_HI_MSB = 7;
  //=========================================================================
  // Register map
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] INIT_OFS = 12'h004;
  localparam logic [11:0] RING_OFS = 12'h008;
  localparam logic [11:0] STAT_OFS = 12'h00c;
  localparam int CTRL_EN = 0;
  localparam int CTRL_ABORT = 1;
  localparam int CTRL_BADCHK = 2;
  localparam int CTRL_APPEND = 3;
  localparam int CTRL_WIDE = 4;
  localparam int CTRL_TRANSP = 5;
  localparam int CTRL_FILT = 6;
  localparam int CTRL_W = 7;
  localparam int RING_LEN_LSB = 24;
  localparam logic [15:0] CHECK_SHORT = 16'h0002;
  localparam logic [15:0] CHECK_LONG = 16'h0004;
  typedef enum logic [3:0] {
    ST_IDLE, ST_RD0, ST_RD1, ST_RD2, ST_WR3, ST_WR0, ST_CRD, ST_CWR
  } rxdes_state_t;
endpackage : rxdes_pkg

// [shared/rxdes_mem_if.sv]
// Word request channel between the descriptor engine and its memory port.
`timescale 1ns/1ps
`default_nettype none
interface rxdes_mem_if;
  logic req;
  logic we;
  logic [23:0] addr;
  logic [15:0] wdata;
  logic done;
  logic [15:0] rdata;
  modport master (output req, output we, output addr, output wdata, input done, input rdata);
  modport port (input req, input we, input addr, input wdata, output done, output rdata);
endinterface : rxdes_mem_if
`default_nettype wire

// [logic/rxdes_mem_port.sv]
// Registered system memory master for single 16-bit word transfers.
`timescale 1ns/1ps
`default_nettype none
module rxdes_mem_port (
  input wire logic core_clk,
  input wire logic srst,
  rxdes_mem_if.port m,
  output logic mem_req,
  output logic mem_we,
  output logic [23:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata
);
  logic done_q;
  logic [15:0] rdata_q;
  assign m.done = done_q;
  assign m.rdata = rdata_q;
  // The request stays up until the bus acknowledges, so a slow arbiter only stretches it.
  always_ff @(posedge core_clk) begin
    done_q <= 1'b0;
    if (srst) begin
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 24'h000000;
      mem_wdata <= 16'h0000;
      rdata_q <= 16'h0000;
    end else if (mem_req && mem_ack) begin
      mem_req <= 1'b0;
      done_q <= 1'b1;
      rdata_q <= mem_rdata;
    end else if (!mem_req && m.req) begin
      mem_req <= 1'b1;
      mem_we <= m.we;
      mem_addr <= m.addr;
      mem_wdata <= m.wdata;
    end
  end
endmodule : rxdes_mem_port
`default_nettype wire

// [logic/rxdes_event_hold.sv]
// Sticky pending flags for the statistics events, one per counter.
`timescale 1ns/1ps
`default_nettype none
module rxdes_event_hold
  import rxdes_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [CNT_NUM-1:0] evt,
  input wire logic [CNT_NUM-1:0] clr,
  output logic [CNT_NUM-1:0] pend
);
  genvar i;
  generate
    for (i = 0; i < CNT_NUM; i++) begin : g_pend
      // A new event in the clearing cycle survives, so no count is lost.
      always_ff @(posedge core_clk) begin
        if (srst) begin
          pend[i] <= 1'b0;
        end else if (evt[i]) begin
          pend[i] <= 1'b1;
        end else if (clr[i]) begin
          pend[i] <= 1'b0;
        end
      end
    end
  endgenerate
endmodule : rxdes_event_hold
`default_nettype wire

// [logic/rxdes_engine.sv]
// Receive descriptor ring walker and statistics counter updater with APB setup.
`timescale 1ns/1ps
`default_nettype none
module rxdes_engine
  import rxdes_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [CNT_NUM-1:0] evt_pulse,
  input wire logic buf_need,
  input wire logic buf_done,
  input wire logic done_last,
  input wire logic done_valid,
  input wire logic [15:0] done_len,
  input wire logic frm_ui,
  input wire logic frm_reject_info,
  input wire logic frm_bad_check,
  input wire logic frm_local_match,
  input wire logic frm_pf_valid,
  input wire logic frm_pf,
  output logic buf_ready,
  output logic buf_none,
  output logic [23:0] buf_addr,
  output logic [15:0] buf_length,
  output logic busy,
  output logic mem_req,
  output logic mem_we,
  output logic [23:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata
);
  //=========================================================================
  // Registers reached over APB
  logic [CTRL_W-1:0] ctrl_q;
  logic [23:0] init_base_q;
  logic [23:0] ring_base_q;
  logic [2:0] ring_len_q;
  logic [6:0] idx_q;
  logic [CNT_NUM-1:0] pend;
  logic [CNT_NUM-1:0] clr_q;
  logic [CNT_NUM-1:0] evt_gated;
  rxdes_state_t state_q;
  rxdes_mem_if mi ();
  // A counter just written is masked while its flag clears, so it is not counted twice.
  wire [CNT_NUM-1:0] pend_live = pend & ~clr_q;

  wire apb_go = psel && penable && !pready;
  // Writes land on the edge where the master samples pready high.
  wire apb_wr = psel && penable && pready && pwrite;
  wire hit_ctrl = (paddr == CTRL_OFS);
  wire hit_init = (paddr == INIT_OFS);
  wire hit_ring = (paddr == RING_OFS);
  wire hit_stat = (paddr == STAT_OFS);
  wire hit_any = hit_ctrl || hit_init || hit_ring || hit_stat;
  wire [31:0] rd_mux = hit_ctrl ? {25'h0000000, ctrl_q} :
                       hit_init ? {8'h00, init_base_q} :
                       hit_ring ? {5'h00, ring_len_q, ring_base_q} :
                       hit_stat ? {16'h0000, pend, (state_q != ST_IDLE), 1'b0, idx_q} :
                       32'h00000000;

  // One wait state keeps every APB output on a flop.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= apb_go;
      pslverr <= apb_go && !hit_any;
      prdata <= (apb_go && !pwrite) ? rd_mux : 32'h00000000;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      ctrl_q <= '0;
      init_base_q <= 24'h000000;
      ring_base_q <= 24'h000000;
      ring_len_q <= 3'h0;
    end else if (apb_wr) begin
      if (hit_ctrl) ctrl_q <= pwdata[CTRL_W-1:0];
      if (hit_init) init_base_q <= pwdata[23:0];
      if (hit_ring) begin
        ring_base_q <= pwdata[23:0];
        ring_len_q <= pwdata[RING_LEN_LSB+2:RING_LEN_LSB];
      end
    end
  end

  //=========================================================================
  // Statistics events
  // The abort event is dropped at the source while its counting is off.
  assign evt_gated = ctrl_q[CTRL_ABORT] ? evt_pulse :
                     (evt_pulse & ~(CNT_NUM'(1) << CNT_ABORT));

  rxdes_event_hold u_hold (
    .core_clk(core_clk),
    .srst(srst),
    .evt(evt_gated),
    .clr(clr_q),
    .pend(pend)
  );

  function automatic logic [2:0] first_set(input logic [CNT_NUM-1:0] v);
    logic [2:0] r;
    r = 3'h0;
    for (int k = CNT_NUM - 1; k >= 0; k--) begin
      if (v[k]) r = 3'(k);
    end
    return r;
  endfunction : first_set

  //=========================================================================
  // Engine requests and frame status held until served
  logic need_q;
  logic done_q;
  logic last_q;
  logic valid_q;
  logic [15:0] len_q;
  logic ui_q;
  logic rej_q;
  logic badchk_q;
  logic local_q;
  logic pfv_q;
  logic pf_q;
  logic in_frame_q;
  logic [15:0] w0_q;
  logic [15:0] w1_q;
  logic [2:0] sel_q;
  logic [15:0] cval_q;
  logic req_q;
  logic sent_q;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      done_q <= 1'b0;
      last_q <= 1'b0;
      valid_q <= 1'b0;
      len_q <= 16'h0000;
      ui_q <= 1'b0;
      rej_q <= 1'b0;
      badchk_q <= 1'b0;
      local_q <= 1'b0;
      pfv_q <= 1'b0;
      pf_q <= 1'b0;
    end else if (buf_done) begin
      done_q <= 1'b1;
      last_q <= done_last;
      valid_q <= done_valid;
      len_q <= done_len;
      ui_q <= frm_ui;
      rej_q <= frm_reject_info;
      badchk_q <= frm_bad_check;
      local_q <= frm_local_match;
      pfv_q <= frm_pf_valid;
      pf_q <= frm_pf;
    end else if (state_q == ST_WR0 && mi.done) begin
      done_q <= 1'b0;
    end else if (state_q == ST_IDLE && done_q && !valid_q) begin
      done_q <= 1'b0;
    end
  end

  //=========================================================================
  // Address and data of each memory step
  wire [23:0] entry = ring_base_q + {14'h0000, idx_q, 3'h0};
  wire [23:0] cnt_addr = init_base_q + CNT_BASE_OFS + (CNT_STEP * {21'h000000, sel_q});
  wire [6:0] len_mask = 7'((8'h01 << ring_len_q) - 8'h01);
  wire [6:0] idx_next = (idx_q + 7'h01) & len_mask;
  wire transp = ctrl_q[CTRL_TRANSP];
  wire rej_flag = rej_q || (transp && ctrl_q[CTRL_BADCHK] && badchk_q);
  wire addr_flag = transp && ctrl_q[CTRL_FILT] && local_q;
  wire pf_flag = pfv_q && pf_q;
  wire [15:0] extra = !ctrl_q[CTRL_APPEND] ? 16'h0000 :
                      ctrl_q[CTRL_WIDE] ? CHECK_LONG : CHECK_SHORT;
  wire [15:0] msg_len = 16'(~(len_q + extra) + 16'h0001);
  // Bits 14 and 7:0 go back exactly as fetched; bit 15 is cleared to hand over.
  wire [15:0] w0_new = {1'b0, w0_q[SEC_BIT], !in_frame_q, last_q, ui_q, rej_flag, addr_flag,
                        pf_flag, w0_q[ADDR_HI_MSB:0]};

  assign mi.req = req_q;
  assign mi.we = (state_q == ST_WR3) || (state_q == ST_WR0) || (state_q == ST_CWR);
  assign mi.addr = (state_q == ST_RD1) ? entry + DW1_OFS :
                   (state_q == ST_RD2) ? entry + DW2_OFS :
                   (state_q == ST_WR3) ? entry + DW3_OFS :
                   (state_q == ST_CRD || state_q == ST_CWR) ? cnt_addr :
                   entry + DW0_OFS;
  assign mi.wdata = (state_q == ST_WR3) ? msg_len :
                    (state_q == ST_CWR) ? cval_q + 16'h0001 : w0_new;

  rxdes_mem_port u_port (
    .core_clk(core_clk),
    .srst(srst),
    .m(mi),
    .mem_req(mem_req),
    .mem_we(mem_we),
    .mem_addr(mem_addr),
    .mem_wdata(mem_wdata),
    .mem_ack(mem_ack),
    .mem_rdata(mem_rdata)
  );

  wire step_mem = (state_q != ST_IDLE);
  wire fire = step_mem && !sent_q;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      req_q <= 1'b0;
      sent_q <= 1'b0;
    end else begin
      req_q <= fire;
      sent_q <= mi.done ? 1'b0 : (fire ? 1'b1 : sent_q);
    end
  end

  //=========================================================================
  // Descriptor and counter sequencer
  // Buffer work goes first; counters are only bookkeeping and may lag.
  always_ff @(posedge core_clk) begin
    buf_ready <= 1'b0;
    buf_none <= 1'b0;
    clr_q <= '0;
    if (srst) begin
      state_q <= ST_IDLE;
      need_q <= 1'b0;
      idx_q <= 7'h00;
      in_frame_q <= 1'b0;
      w0_q <= 16'h0000;
      w1_q <= 16'h0000;
      sel_q <= 3'h0;
      cval_q <= 16'h0000;
      buf_addr <= 24'h000000;
      buf_length <= 16'h0000;
      busy <= 1'b0;
    end else begin
      if (buf_need) need_q <= 1'b1;
      busy <= (state_q != ST_IDLE) || need_q || done_q || (pend != '0);
      unique case (state_q)
        ST_IDLE: begin
          if (done_q && valid_q) begin
            state_q <= last_q ? ST_WR3 : ST_WR0;
          end else if (done_q) begin
            // A bad frame keeps the entry; the next request fetches it again.
            in_frame_q <= 1'b0;
          end else if (need_q && !ctrl_q[CTRL_EN]) begin
            need_q <= 1'b0;
            buf_none <= 1'b1;
          end else if (need_q) begin
            state_q <= ST_RD0;
          end else if (pend_live != '0) begin
            sel_q <= first_set(pend_live);
            state_q <= ST_CRD;
          end
        end
        ST_RD0: begin
          if (mi.done) begin
            w0_q <= mi.rdata;
            need_q <= 1'b0;
            if (mi.rdata[OWN_BIT]) begin
              state_q <= ST_RD1;
            end else begin
              buf_none <= 1'b1;
              state_q <= ST_IDLE;
            end
          end
        end
        ST_RD1: begin
          if (mi.done) begin
            w1_q <= mi.rdata;
            state_q <= ST_RD2;
          end
        end
        ST_RD2: begin
          if (mi.done) begin
            buf_addr <= {w0_q[ADDR_HI_MSB:0], w1_q};
            buf_length <= mi.rdata;
            buf_ready <= 1'b1;
            state_q <= ST_IDLE;
          end
        end
        ST_WR3: begin
          if (mi.done) state_q <= ST_WR0;
        end
        ST_WR0: begin
          if (mi.done) begin
            idx_q <= idx_next;
            in_frame_q <= !last_q;
            state_q <= ST_IDLE;
          end
        end
        ST_CRD: begin
          if (mi.done) begin
            cval_q <= mi.rdata;
            state_q <= ST_CWR;
          end
        end
        ST_CWR: begin
          if (mi.done) begin
            clr_q <= CNT_NUM'(1) << sel_q;
            state_q <= ST_IDLE;
          end
        end
      endcase
    end
  end
endmodule : rxdes_engine
`default_nettype wire

// [verification/rxdes_engine_properties.sv]
// Concurrent checks on the descriptor engine's memory and buffer ports.
`timescale 1ns/1ps
`default_nettype none
module rxdes_checker
  import rxdes_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic buf_need,
  input wire logic buf_ready,
  input wire logic buf_none,
  input wire logic buf_done,
  input wire logic [15:0] done_len,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [23:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata
);
  //==========================================================================
  // Helper state
  logic [23:0] init_q;
  logic [23:0] ad_q;
  logic [6:0] ctrl_q;
  logic [15:0] rd_q;
  logic [15:0] w0_q;
  logic [15:0] len_q;
  logic [15:0] chk;
  logic apb_wr;
  logic in_cnt;
  logic wr;
  logic w0;
  assign apb_wr = psel && penable && pready && pwrite && !pslverr;
  assign in_cnt = mem_addr >= init_q + CNT_BASE_OFS && mem_addr < init_q + CNT_BASE_OFS + 24'he;
  assign wr = mem_req && mem_we;
  assign w0 = wr && !in_cnt && mem_addr[2:0] == 3'h0;
  assign chk = !ctrl_q[CTRL_APPEND] ? 16'h0 : ctrl_q[CTRL_WIDE] ? CHECK_LONG : CHECK_SHORT;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      init_q <= 24'h0;
      ctrl_q <= 7'h0;
    end else begin
      if (apb_wr && paddr == INIT_OFS) init_q <= pwdata[23:0];
      if (apb_wr && paddr == CTRL_OFS) ctrl_q <= pwdata[6:0];
      if (mem_req && mem_ack && !mem_we) begin
        rd_q <= mem_rdata;
        ad_q <= mem_addr;
        if (!in_cnt && mem_addr[2:0] == 3'h0) w0_q <= mem_rdata;
      end
      if (buf_done) len_q <= done_len;
    end
  end
  //==========================================================================
  // Properties
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  property p_release; w0 |-> !mem_wdata[OWN_BIT]; endproperty
  a_release: assert property (p_release) else $error("owner flag left set");
  property p_kept; w0 |-> mem_wdata[7:0] == w0_q[7:0] && mem_wdata[14] == w0_q[14]; endproperty
  a_kept: assert property (p_kept) else $error("pointer or helper flag altered");
  property p_words; wr && !in_cnt |-> mem_addr[2:1] == 2'h0 || mem_addr[2:1] == 2'h3; endproperty
  a_words: assert property (p_words) else $error("wrote a host word");
  property p_len; wr && !in_cnt && mem_addr[2:1] == 2'h3 |-> mem_wdata == 16'h0 - (len_q + chk);
  endproperty
  a_len: assert property (p_len) else $error("bad frame length");
  property p_incr; wr && in_cnt |-> mem_wdata == rd_q + 16'h1 && mem_addr == ad_q; endproperty
  a_incr: assert property (p_incr) else $error("counter not incremented");
  property p_abort; wr && mem_addr == init_q + 24'h38 |-> ctrl_q[CTRL_ABORT]; endproperty
  a_abort: assert property (p_abort) else $error("abort counted while off");
  property p_hold;
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_wdata) && $stable(mem_we);
  endproperty
  a_hold: assert property (p_hold) else $error("memory request dropped");
  property p_answer; buf_need |-> ##[2:400] (buf_ready || buf_none); endproperty
  a_answer: assert property (p_answer) else $error("buffer request unanswered");
endmodule : rxdes_checker
`default_nettype wire

// [verification/rxdes_host_mem.sv]
// Host memory model answering the engine's word requests with a settable lag.
`timescale 1ns/1ps
`default_nettype none
module rxdes_host_mem (
  input wire logic core_clk,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [23:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic [3:0] lag,
  output logic mem_ack,
  output logic [15:0] mem_rdata
);
  //==========================================================================
  // Storage
  // Only 512 bytes exist, so the ring and init area must sit low.
  logic [15:0] words [0:255];
  logic [3:0] wait_q;
  initial begin
    mem_ack = 1'b0;
    mem_rdata = 16'h0;
    wait_q = 4'h0;
    for (int k = 0; k < 256; k++) words[k] = 16'h0;
  end
  always @(posedge core_clk) begin
    if (mem_req && !mem_ack && wait_q >= lag) begin
      mem_ack <= 1'b1;
      mem_rdata <= words[mem_addr[8:1]];
      if (mem_we) words[mem_addr[8:1]] <= mem_wdata;
      wait_q <= 4'h0;
    end else begin
      mem_ack <= 1'b0;
      // Data toggles outside an answer so a stale capture shows.
      mem_rdata <= ~mem_rdata;
      wait_q <= (mem_req && !mem_ack) ? wait_q + 4'h1 : 4'h0;
    end
  end
endmodule : rxdes_host_mem
`default_nettype wire

// [verification/test_rx_descriptor_and_error_stats.sv]
// Self-checking bench for the receive descriptor and statistics engine.
`timescale 1ns/1ps
`default_nettype none
module test_rx_descriptor_and_error_stats import rxdes_pkg::*;;
  logic core_clk, srst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [CNT_NUM-1:0] evt_pulse;
  logic buf_need, buf_done, done_last, done_valid, buf_ready, buf_none, busy;
  logic frm_ui, frm_reject_info, frm_bad_check, frm_local_match, frm_pf_valid, frm_pf;
  logic [15:0] done_len, buf_length, mem_wdata, mem_rdata;
  logic [23:0] buf_addr, mem_addr;
  logic mem_req, mem_we, mem_ack, err;
  logic [3:0] lag;
  int fails = 0;
  int compares = 0;
  int cycles = 0;
  rxdes_engine dut (.core_clk, .srst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .evt_pulse, .buf_need, .buf_done, .done_last, .done_valid, .done_len,
    .frm_ui, .frm_reject_info, .frm_bad_check, .frm_local_match, .frm_pf_valid, .frm_pf,
    .buf_ready, .buf_none, .buf_addr, .buf_length, .busy, .mem_req, .mem_we, .mem_addr,
    .mem_wdata, .mem_ack, .mem_rdata);
  rxdes_host_mem host (.core_clk, .mem_req, .mem_we, .mem_addr, .mem_wdata, .lag, .mem_ack,
    .mem_rdata);
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  //==========================================================================
  // Tasks
  task automatic wrap_up();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      wrap_up();
    end
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic pulse(input logic [6:0] v);
    @(posedge core_clk);
    evt_pulse <= v;
    @(posedge core_clk);
    evt_pulse <= 7'h0;
  endtask : pulse
  task automatic settle();
    repeat (4) @(posedge core_clk);
    while (busy !== 1'b0) @(posedge core_clk);
  endtask : settle
  task automatic fetch(input int b, input logic own);
    @(posedge core_clk);
    buf_need <= 1'b1;
    @(posedge core_clk);
    buf_need <= 1'b0;
    do @(posedge core_clk); while (buf_ready !== 1'b1 && buf_none !== 1'b1);
    check("buf_ready", buf_ready, own);
    check("buf_none", buf_none, !own);
    if (own) begin
      check("buf_addr", buf_addr, {host.words[b][7:0], host.words[b+1]});
      check("buf_length", buf_length, host.words[b+2]);
    end
  endtask : fetch
  task automatic frame(input int i, input logic [7:0] f, input logic [15:0] len,
    input logic [15:0] w0, input logic [15:0] w3);
    fetch(4 * i, 1'b1);
    @(posedge core_clk);
    {done_last, done_valid, frm_ui, frm_reject_info} <= f[7:4];
    {frm_bad_check, frm_local_match, frm_pf_valid, frm_pf} <= f[3:0];
    done_len <= len;
    buf_done <= 1'b1;
    @(posedge core_clk);
    buf_done <= 1'b0;
    settle();
    check("word0", host.words[4*i], w0);
    check("word1", host.words[4*i+1], {8'h20 + 8'(i), 8'h00});
    check("word2", host.words[4*i+2], 16'hffc0);
    check("word3", host.words[4*i+3], w3);
  endtask : frame
  //==========================================================================
  // Sequence
  initial begin
    {srst, psel, penable, pwrite, buf_need, buf_done, done_last, done_valid} = 8'h80;
    {frm_ui, frm_reject_info, frm_bad_check, frm_local_match, frm_pf_valid, frm_pf} = 6'h0;
    {paddr, pwdata, evt_pulse, done_len, lag} = '0;
    repeat (12) @(posedge core_clk);
    srst <= 1'b0;
    for (int k = 0; k < 7; k++) host.words[8'h96+k] = 16'(16'h0010 * k);
    host.words[8'h96] = 16'hffff;
    host.words[8'h9d] = 16'h0;
    host.words[8'h9e] = 16'h0;
    for (int k = 0; k < 4; k++) begin
      host.words[4*k] = {1'b1, k == 0, 6'h0, 8'h10 + 8'(k)};
      host.words[4*k+1] = {8'h20 + 8'(k), 8'h00};
      host.words[4*k+2] = 16'hffc0;
      host.words[4*k+3] = 16'h5a5a;
    end
    apb(1'b0, CTRL_OFS, 32'h0);
    check("ctrl", rd, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    check("slverr", err, 1'b1);
    apb(1'b1, INIT_OFS, 32'h100);
    apb(1'b1, RING_OFS, 32'h0200_0000);
    apb(1'b0, INIT_OFS, 32'h0);
    check("init", rd, 32'h100);
    $display("register test done");
    apb(1'b1, CTRL_OFS, 32'h1);
    pulse(7'h7f);
    settle();
    check("counter0", host.words[8'h96], 16'h0);
    for (int k = 1; k < 6; k++) check("counter", host.words[8'h96+k], 16'h10 * k + 1);
    check("abort", host.words[8'h9c], 16'h60);
    apb(1'b1, CTRL_OFS, 32'h3);
    pulse(7'h40);
    settle();
    check("abort", host.words[8'h9c], 16'h61);
    check("reserved", host.words[8'h9d], 16'h0);
    $display("counter test done");
    apb(1'b1, CTRL_OFS, 32'h7d);
    lag <= 4'h2;
    frame(0, 8'b1110_0011, 16'd10, 16'h7910, 16'hfff2);
    frame(1, 8'b0100_1100, 16'd64, 16'h2611, 16'h5a5a);
    frame(2, 8'b1100_0010, 16'd20, 16'h1012, 16'hffe8);
    frame(3, 8'b1000_0000, 16'd20, 16'h8013, 16'h5a5a);
    apb(1'b1, CTRL_OFS, 32'h9);
    frame(3, 8'b1101_1100, 16'd2, 16'h3413, 16'hfffc);
    apb(1'b0, STAT_OFS, 32'h0);
    check("index", rd[6:0], 7'h0);
    fetch(0, 1'b0);
    host.words[0] = 16'h8010;
    fetch(0, 1'b1);
    apb(1'b1, CTRL_OFS, 32'h0);
    fetch(0, 1'b0);
    $display("descriptor test done");
    wrap_up();
  end
endmodule : test_rx_descriptor_and_error_stats
bind rxdes_engine rxdes_checker chk (.core_clk, .srst, .paddr, .psel, .penable, .pwrite,
  .pwdata, .pready, .pslverr, .buf_need, .buf_ready, .buf_none, .buf_done, .done_len,
  .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata);
`default_nettype wire
